/* hw/tw_pkg.sv */
// constants, states and carrier types for the two-wire register access slave
package tw_pkg;

    // ==================================================================
    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int TOUT_MS = 30;
    // longest time: integer division rounds down
    localparam int TOUT_CYC = (CLK_HZ / 1000) * TOUT_MS;

    // ==================================================================
    // input spike filter lengths, in clock cycles
    localparam int FILT_W = 3;
    localparam logic [2:0] FILT_FAST = 3'h2;
    localparam logic [2:0] FILT_HS = 3'h1;

    // ==================================================================
    // bus codes
    localparam logic [6:0] DEV_ADDR = 7'h4c;
    localparam logic [7:0] GCALL_ADDR = 8'h00;
    localparam logic [7:0] GCALL_RESET = 8'h06;
    localparam logic [4:0] HS_CODE = 5'h01;
    localparam logic [3:0] BIT_LAST = 4'h8;

    // ==================================================================
    // register map
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] HYST_PTR = 8'h21;
    localparam logic [7:0] HYST_RST = 8'h0a;
    localparam int HYST_MSB = 7;
    localparam int HYST_LSB = 0;

    // ==================================================================
    // byte-level state, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WR_BYTE = 3'h2,
        ST_WR_ACK = 3'h6,
        ST_RD_BYTE = 3'h7,
        ST_RD_ACK = 3'h5,
        ST_WAIT = 3'h4
    } tw_state_t;

    // register write strobe towards the rest of the device
    typedef struct packed {
        logic valid;
        logic [7:0] ptr;
        logic [7:0] data;
    } tw_wr_t;

endpackage

/* hw/tw_in_filt.sv */
// two-flop synchroniser and spike filter for one bus input
`timescale 1ns/100ps
`default_nettype none
module tw_in_filt #(
    parameter int LEN_W = tw_pkg::FILT_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // pin and filter length
    input wire logic pin_i,
    input wire logic [LEN_W-1:0] len_i,
    // filtered level
    output logic level_o
);
    import tw_pkg::*;

    logic meta_reg, meta_next;
    logic sync_reg, sync_next;
    logic level_reg, level_next;
    logic [LEN_W-1:0] cnt_reg, cnt_next;

    // level follows the synced pin only once it has stood len_i cycles
    always_comb begin
        meta_next = pin_i;
        sync_next = meta_reg;
        level_next = level_reg;
        cnt_next = '0;
        if (sync_reg != level_reg) begin
            if (cnt_reg + 1'b1 >= len_i) begin
                level_next = sync_reg;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    // bus idles high
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            level_reg <= 1'b1;
            cnt_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            level_reg <= level_next;
            cnt_reg <= cnt_next;
        end
    end

    assign level_o = level_reg;

endmodule
`default_nettype wire

/* hw/tw_slave.sv */
// two-wire slave with pointer, hysteresis register and register strobes
`timescale 1ns/100ps
`default_nettype none
// How it works
// (RULE1) hysteresis resets to ten degrees in every range setting
// (RULE2) hysteresis register sits at pointer 21h, resets to 0Ah
// (RULE3) hysteresis is unsigned 8-bit whole degrees, bit 7 most significant
// (RULE4) software keeps hysteresis below every high and alarm limit
// (RULE5) slave only: never drives SCL, START or STOP
// (RULE6) works from 1 kHz up to fast and high-speed rates
// (RULE7) every byte shifts most significant bit first
// (RULE8) first byte after START is 7-bit address plus direction, 4Ch
// (RULE9) own address acknowledged by pulling SDA low on ninth clock
// (RULE10) START is SDA fall with SCL high, STOP SDA rise
// (RULE11) SDA changes only while SCL low; high-phase change is control
// (RULE12) first byte of a write loads the pointer
// (RULE13) reads use the last written pointer, kept until next write
// (RULE14) master changes read target by pointer write then restart
// (RULE15) two-byte registers go high byte first, then low byte
// (RULE16) byte count set by master; receiver acknowledges every byte
// (RULE17) acknowledge holds SDA low over the whole ack clock high phase
// (RULE18) master ends a read by not acknowledging the last byte
// (RULE19) transfers end with STOP or repeated START; idle is both high
// (RULE20) SDA and SCL inputs are spike filtered before use
// (RULE21) with time-out enabled, 30 ms low in a transfer resets interface
// (RULE22) general call with second byte 06h resets registers, else nothing
// (RULE23) high-speed master code is not acknowledged, filters shortened till STOP
// (RULE24) SDA and SCL pass two flip-flops before edge detection
// (RULE25) unaddressed the slave keeps SDA released and waits after STOP
module tw_slave #(
    parameter int TOUT_CYCLES = tw_pkg::TOUT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // configuration
    input wire logic timeout_en_i,
    // pointer-selected register access
    output logic [7:0] reg_ptr_o,
    output tw_pkg::tw_wr_t reg_wr_o,
    output logic reg_rd_o,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_wide_i,
    // status and own register
    output logic [7:0] hysteresis_value_o,
    output logic soft_rst_o,
    output logic hs_mode_o
);
    import tw_pkg::*;

    localparam int TW = $clog2(TOUT_CYCLES + 1);

    // ==================================================================
    // input conditioning
    logic scl_f, sda_f;
    logic scl_q_reg, sda_q_reg;
    logic hs_reg, hs_next;
    logic [FILT_W-1:0] filt_len;

    // (RULE23) high-speed shortens filters
    assign filt_len = hs_reg ? FILT_HS : FILT_FAST;

    // (RULE20) spike filter on scl
    tw_in_filt #(.LEN_W(FILT_W)) u_scl_filt (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(scl_i),
        .len_i(filt_len),
        .level_o(scl_f)
    );

    // (RULE24) sync and filter on sda
    tw_in_filt #(.LEN_W(FILT_W)) u_sda_filt (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(sda_i),
        .len_i(filt_len),
        .level_o(sda_f)
    );

    // (RULE6) edges at any bus rate
    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_f & ~scl_q_reg;
    assign scl_fall = ~scl_f & scl_q_reg;
    // (RULE10) control conditions
    assign start_det = scl_f & scl_q_reg & sda_q_reg & ~sda_f;
    assign stop_det = scl_f & scl_q_reg & ~sda_q_reg & sda_f;

    // ==================================================================
    // protocol state
    tw_state_t state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] tx_reg, tx_next;
    logic oe_reg, oe_next;
    logic rw_reg, rw_next;
    logic first_reg, first_next;
    logic gc_reg, gc_next;
    logic hi_reg, hi_next;
    logic ackd_reg, ackd_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] hyst_reg, hyst_next;
    tw_wr_t wr_reg, wr_next;
    logic rd_reg, rd_next;
    logic srst_reg, srst_next;
    logic [TW-1:0] tout_reg, tout_next;

    // byte to send next, picked from pointer
    logic wide;
    logic [7:0] rd_byte;
    assign wide = (ptr_reg != HYST_PTR) & reg_wide_i;
    // (RULE15) high byte before low byte
    assign rd_byte = (ptr_reg == HYST_PTR) ? hyst_reg :
                     (wide & hi_reg) ? reg_rdata_i[15:8] : reg_rdata_i[7:0];

    // next-state logic for the whole slave
    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        tx_next = tx_reg;
        oe_next = oe_reg;
        rw_next = rw_reg;
        first_next = first_reg;
        gc_next = gc_reg;
        hi_next = hi_reg;
        ackd_next = ackd_reg;
        ptr_next = ptr_reg;
        hyst_next = hyst_reg;
        hs_next = hs_reg;
        wr_next = '0;
        rd_next = 1'b0;
        srst_next = 1'b0;
        // (RULE21) stuck-low time-out counter
        if (timeout_en_i && state_reg != ST_IDLE && (!scl_f || !sda_f)) begin
            tout_next = tout_reg + 1'b1;
        end else begin
            tout_next = '0;
        end
        if (start_det) begin
            // (RULE19) repeated start restarts address phase
            state_next = ST_ADDR;
            bit_next = '0;
            oe_next = 1'b0;
            gc_next = 1'b0;
        end else if (stop_det) begin
            // (RULE25) release and wait for start
            state_next = ST_IDLE;
            oe_next = 1'b0;
            hs_next = 1'b0;
        end else if (tout_reg >= TW'(TOUT_CYCLES)) begin
            // (RULE21) time-out releases the bus
            state_next = ST_IDLE;
            oe_next = 1'b0;
            hs_next = 1'b0;
            tout_next = '0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_WR_BYTE: begin
                    if (scl_rise && bit_reg != BIT_LAST) begin
                        // (RULE7) shift in msb first
                        sh_next = {sh_reg[6:0], sda_f};
                        bit_next = bit_reg + 1'b1;
                    end else if (scl_fall && bit_reg == BIT_LAST) begin
                        bit_next = '0;
                        if (state_reg == ST_ADDR) begin
                            if (sh_reg[7:1] == DEV_ADDR) begin
                                // (RULE8) (RULE9) match and ack
                                oe_next = 1'b1;
                                rw_next = sh_reg[0];
                                hi_next = 1'b1;
                                state_next = ST_ADDR_ACK;
                            end else if (sh_reg == GCALL_ADDR) begin
                                // (RULE22) general call acked
                                oe_next = 1'b1;
                                rw_next = 1'b0;
                                gc_next = 1'b1;
                                state_next = ST_ADDR_ACK;
                            end else if (sh_reg[7:3] == HS_CODE) begin
                                // (RULE23) master code, no ack
                                hs_next = 1'b1;
                                state_next = ST_WAIT;
                            end else begin
                                // (RULE25) not ours, stay released
                                state_next = ST_WAIT;
                            end
                        end else begin
                            // (RULE16) ack every received byte
                            oe_next = 1'b1;
                            state_next = ST_WR_ACK;
                            first_next = 1'b0;
                            if (gc_reg) begin
                                // (RULE22) reset only on 06h
                                if (first_reg && sh_reg == GCALL_RESET) begin
                                    srst_next = 1'b1;
                                    hyst_next = HYST_RST;
                                    ptr_next = PTR_RST;
                                end
                            end else if (first_reg) begin
                                // (RULE12) first byte loads pointer
                                ptr_next = sh_reg;
                            end else if (ptr_reg == HYST_PTR) begin
                                // (RULE2) hysteresis write
                                hyst_next = sh_reg;
                            end else begin
                                wr_next = '{valid: 1'b1, ptr: ptr_reg, data: sh_reg};
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        first_next = 1'b1;
                        bit_next = '0;
                        if (rw_reg) begin
                            // (RULE13) read from held pointer
                            tx_next = rd_byte;
                            oe_next = ~rd_byte[7];
                            hi_next = wide ? ~hi_reg : hi_reg;
                            rd_next = 1'b1;
                            state_next = ST_RD_BYTE;
                        end else begin
                            oe_next = 1'b0;
                            state_next = ST_WR_BYTE;
                        end
                    end
                end
                ST_WR_ACK: begin
                    // (RULE17) ack held until scl falls again
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        state_next = ST_WR_BYTE;
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_rise) begin
                        bit_next = bit_reg + 1'b1;
                    end else if (scl_fall) begin
                        if (bit_reg == BIT_LAST) begin
                            oe_next = 1'b0;
                            bit_next = '0;
                            state_next = ST_RD_ACK;
                        end else begin
                            // (RULE11) change sda while scl low
                            tx_next = {tx_reg[6:0], 1'b0};
                            oe_next = ~tx_reg[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        ackd_next = ~sda_f;
                    end else if (scl_fall) begin
                        if (ackd_reg) begin
                            tx_next = rd_byte;
                            oe_next = ~rd_byte[7];
                            hi_next = wide ? ~hi_reg : hi_reg;
                            rd_next = 1'b1;
                            state_next = ST_RD_BYTE;
                        end else begin
                            // (RULE18) nack ends the read
                            state_next = ST_WAIT;
                        end
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    oe_next = 1'b0;
                end
                default: begin
                    state_next = ST_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    // registers of the protocol state
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            state_reg <= ST_IDLE;
            bit_reg <= '0;
            sh_reg <= '0;
            tx_reg <= '0;
            oe_reg <= 1'b0;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            gc_reg <= 1'b0;
            hi_reg <= 1'b1;
            ackd_reg <= 1'b0;
            ptr_reg <= PTR_RST;
            // (RULE1) ten degrees after reset
            hyst_reg <= HYST_RST;
            hs_reg <= 1'b0;
            wr_reg <= '0;
            rd_reg <= 1'b0;
            srst_reg <= 1'b0;
            tout_reg <= '0;
        end else begin
            scl_q_reg <= scl_f;
            sda_q_reg <= sda_f;
            state_reg <= state_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            tx_reg <= tx_next;
            oe_reg <= oe_next;
            rw_reg <= rw_next;
            first_reg <= first_next;
            gc_reg <= gc_next;
            hi_reg <= hi_next;
            ackd_reg <= ackd_next;
            ptr_reg <= ptr_next;
            hyst_reg <= hyst_next;
            hs_reg <= hs_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            srst_reg <= srst_next;
            tout_reg <= tout_next;
        end
    end

    // ==================================================================
    // outputs
    // (RULE5) open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_reg;
    assign reg_ptr_o = ptr_reg;
    assign reg_wr_o = wr_reg;
    assign reg_rd_o = rd_reg;
    // (RULE3) unsigned whole degrees, bit 7 msb
    assign hysteresis_value_o = hyst_reg[HYST_MSB:HYST_LSB];
    assign soft_rst_o = srst_reg;
    assign hs_mode_o = hs_reg;

endmodule
`default_nettype wire

/* sim/tw_slave_properties.sv */
// assertion checker for the two-wire slave ports
`timescale 1ns/100ps
`default_nettype none
module tw_slave_properties #(
    parameter int TOUT_CYCLES = 200
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // bus side
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic timeout_en_i,
    // register side
    input wire logic [7:0] reg_ptr_o,
    input wire tw_pkg::tw_wr_t reg_wr_o,
    input wire logic reg_rd_o,
    input wire logic [7:0] hysteresis_value_o,
    input wire logic soft_rst_o,
    input wire logic hs_mode_o
);
    import tw_pkg::*;
    // ==========================================================
    // stuck-low counter
    int low_cnt_reg;
    int low_cnt_next;
    int tout_lim;
    assign tout_lim = TOUT_CYCLES + 12;
    // counts cycles of scl low with time-out on
    always_comb begin
        low_cnt_next = (!srst_i && timeout_en_i && !scl_i) ? low_cnt_reg + 1 : 0;
    end
    always_ff @(posedge clk_i) begin
        low_cnt_reg <= low_cnt_next;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // ==========================================================
    // properties
    open_drain_low_a: assert property (sda_o == 1'b0)
        else $error("sda output value not low");
    reset_values_a: assert property ($fell(srst_i) |->
        hysteresis_value_o == HYST_RST && reg_ptr_o == PTR_RST && !sda_oe_o)
        else $error("wrong values after reset");
    gcall_restore_a: assert property (soft_rst_o |=>
        hysteresis_value_o == HYST_RST && reg_ptr_o == PTR_RST)
        else $error("general call reset did not restore");
    soft_pulse_a: assert property (soft_rst_o |=> !soft_rst_o)
        else $error("soft reset longer than one cycle");
    rd_pulse_a: assert property (reg_rd_o |=> !reg_rd_o)
        else $error("read strobe longer than one cycle");
    wr_strobe_a: assert property (reg_wr_o.valid |->
        reg_wr_o.ptr != HYST_PTR && reg_wr_o.ptr == reg_ptr_o)
        else $error("write strobe at wrong pointer");
    hyst_write_a: assert property ($changed(hysteresis_value_o) |->
        reg_ptr_o == HYST_PTR || hysteresis_value_o == HYST_RST)
        else $error("hysteresis changed at other pointer");
    ack_width_a: assert property ($rose(sda_oe_o) |=> sda_oe_o [*2])
        else $error("sda pull shorter than three cycles");
    hs_no_ack_a: assert property ($rose(hs_mode_o) |-> !sda_oe_o [*8])
        else $error("master code was acknowledged");
    stuck_release_a: assert property (low_cnt_reg == tout_lim |-> !sda_oe_o)
        else $error("sda held past time-out");
    cover property (soft_rst_o);
    cover property ($rose(hs_mode_o));
    cover property (reg_wr_o.valid);
    cover property (reg_rd_o ##[1:40] reg_rd_o);
endmodule
bind tw_slave tw_slave_properties #(.TOUT_CYCLES(TOUT_CYCLES)) u_props (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .timeout_en_i(timeout_en_i), .reg_ptr_o(reg_ptr_o),
    .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
    .hysteresis_value_o(hysteresis_value_o), .soft_rst_o(soft_rst_o),
    .hs_mode_o(hs_mode_o));
`default_nettype wire

/* sim/tw_bus_master.sv */
// behavioural two-wire bus master that drives the slave's pins
`timescale 1ns/100ps
`default_nettype none
module tw_bus_master (
    // clock
    input wire logic clk_i,
    // bus pins, pull_o high pulls sda low
    input wire logic sda_i,
    output logic scl_o,
    output logic pull_o
);
    // ==========================================================
    // bit and byte tasks, 800 ns scl period
    int stretch;
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
        stretch = 0;
    end
    task automatic tk(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic start();
        pull_o = 1'b1;
        tk(4);
    endtask
    // data moves in low phase, sampled twice in high phase
    task automatic bitx(input logic b, output logic s, output logic s2);
        scl_o = 1'b0;
        tk(2);
        pull_o = !b;
        tk(3 + stretch);
        scl_o = 1'b1;
        tk(1);
        s = sda_i;
        tk(2);
        s2 = sda_i;
    endtask
    // byte out msb first, ack low over whole high phase
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        logic s2;
        for (int i = 7; i >= 0; i--) bitx(d[i], s, s2);
        bitx(1'b1, s, s2);
        ack = !s && !s2;
    endtask
    // byte in, last one left unacknowledged
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s2;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i], s2);
        bitx(nack, s2, s2);
    endtask
    // stop: sda rises while scl high
    task automatic stop();
        scl_o = 1'b0;
        tk(2);
        pull_o = 1'b1;
        tk(3);
        scl_o = 1'b1;
        tk(4);
        pull_o = 1'b0;
        tk(6);
    endtask
    // stuck master holding scl low
    task automatic hold(input int n);
        scl_o = 1'b0;
        tk(n);
    endtask
    // one-cycle spike on sda while idle
    task automatic spike();
        pull_o = 1'b1;
        tk(1);
        pull_o = 1'b0;
        tk(2);
    endtask
endmodule
`default_nettype wire

/* sim/tb_two_wire_register_access.sv */
// self-checking bench for the two-wire register access slave
`timescale 1ns/100ps
`default_nettype none
module tb_two_wire_register_access;
    import tw_pkg::*;
    localparam int TOUT = 200;
    logic clk_i;
    logic srst_i;
    logic timeout_en_i;
    logic [15:0] reg_rdata_i;
    logic reg_wide_i;
    logic scl_w;
    logic pull_w;
    logic sda_o;
    logic sda_oe_o;
    logic [7:0] reg_ptr_o;
    tw_wr_t reg_wr_o;
    tw_wr_t last_wr;
    logic reg_rd_o;
    logic [7:0] hysteresis_value_o;
    logic soft_rst_o;
    logic hs_mode_o;
    logic ack;
    logic s1;
    logic s2;
    logic [7:0] rd;
    int n_fail;
    int checks_done;
    int n_rst;
    int n_rd;
    // open-drain wire with pull-up
    wire logic sda_w = !(sda_oe_o || pull_w);
    // ==========================================================
    // clock, parts and monitors
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    tw_slave #(.TOUT_CYCLES(TOUT)) dut (.clk_i(clk_i), .srst_i(srst_i),
        .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .timeout_en_i(timeout_en_i), .reg_ptr_o(reg_ptr_o), .reg_wr_o(reg_wr_o),
        .reg_rd_o(reg_rd_o), .reg_rdata_i(reg_rdata_i), .reg_wide_i(reg_wide_i),
        .hysteresis_value_o(hysteresis_value_o), .soft_rst_o(soft_rst_o),
        .hs_mode_o(hs_mode_o));
    tw_bus_master m (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .pull_o(pull_w));
    always @(posedge clk_i) begin
        if (soft_rst_o === 1'b1) n_rst++;
        if (reg_rd_o === 1'b1) n_rd++;
        if (reg_wr_o.valid === 1'b1) last_wr = reg_wr_o;
    end
    // ==========================================================
    // compare, verdict and bus sequences
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] p, input logic [7:0] d, input bit dat);
        m.start();
        m.wbyte({DEV_ADDR, 1'b0}, ack);
        check(ack, 1'b1);
        m.wbyte(p, ack);
        check(ack, 1'b1);
        if (dat) begin
            m.wbyte(d, ack);
            check(ack, 1'b1);
        end
        m.stop();
    endtask
    task automatic rd_one(input logic [7:0] exp);
        m.start();
        m.wbyte({DEV_ADDR, 1'b1}, ack);
        check(ack, 1'b1);
        m.rbyte(1'b1, rd);
        check(rd, exp);
        m.stop();
    endtask
    // watchdog against a hung run
    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        finish_test();
    end
    initial begin
        n_fail = 0;
        checks_done = 0;
        n_rst = 0;
        n_rd = 0;
        last_wr = '0;
        srst_i = 1'b1;
        timeout_en_i = 1'b1;
        reg_rdata_i = 16'ha5c3;
        reg_wide_i = 1'b0;
        repeat (20) @(negedge clk_i);
        srst_i = 1'b0;
        repeat (6) @(negedge clk_i);
        check(hysteresis_value_o, 8'h0a);
        check(reg_ptr_o, 8'h00);
        wr_reg(8'h21, 8'h96, 1'b1);
        check(hysteresis_value_o, 8'h96);
        check(last_wr.valid, 1'b0);
        rd_one(8'h96);
        $display("test hysteresis done");
        // pointer only, repeated start, slow two-byte read, strobed write
        reg_wide_i = 1'b1;
        m.start();
        m.wbyte({DEV_ADDR, 1'b0}, ack);
        check(ack, 1'b1);
        m.wbyte(8'h30, ack);
        check(ack, 1'b1);
        m.bitx(1'b1, s1, s2);
        check(last_wr.valid, 1'b0);
        n_rd = 0;
        m.stretch = 12;
        m.start();
        m.wbyte({DEV_ADDR, 1'b1}, ack);
        m.rbyte(1'b0, rd);
        check(rd, 8'ha5);
        m.rbyte(1'b1, rd);
        check(rd, 8'hc3);
        m.stop();
        m.stretch = 0;
        check(n_rd, 2);
        check(reg_ptr_o, 8'h30);
        wr_reg(8'h30, 8'h7e, 1'b1);
        check({last_wr.ptr, last_wr.data}, 16'h307e);
        check(hysteresis_value_o, 8'h96);
        $display("test pointer done");
        // foreign address and filtered spike get no ack
        m.start();
        m.wbyte({7'h4d, 1'b0}, ack);
        check(ack, 1'b0);
        m.stop();
        m.spike();
        m.wbyte({DEV_ADDR, 1'b0}, ack);
        check(ack, 1'b0);
        m.stop();
        $display("test refusal done");
        // general call, other byte then reset byte
        for (int k = 0; k < 2; k++) begin
            m.start();
            m.wbyte(8'h00, ack);
            check(ack, 1'b1);
            m.wbyte(8'h07 - 8'(k), ack);
            m.stop();
            check(n_rst, k);
            check(hysteresis_value_o, (k == 1) ? 8'h0a : 8'h96);
        end
        check(reg_ptr_o, 8'h00);
        // high-speed master codes, ended by stop
        for (int k = 0; k < 2; k++) begin
            m.start();
            m.wbyte(8'h08 + 8'(7 * k), ack);
            check(ack, 1'b0);
            check(hs_mode_o, 1'b1);
            m.stop();
            check(hs_mode_o, 1'b0);
        end
        $display("test general call done");
        // master stalls scl low during the address ack, time-out off then on
        reg_wide_i = 1'b0;
        for (int k = 0; k < 2; k++) begin
            timeout_en_i = (k == 1);
            m.start();
            for (int i = 7; i >= 0; i--) m.bitx(i != 0 && DEV_ADDR[i - 1], s1, s2);
            m.hold(20);
            check(sda_oe_o, 1'b1);
            m.hold(TOUT + 40);
            check(sda_oe_o, k == 0);
            m.bitx(1'b1, s1, s2);
            m.stop();
        end
        rd_one(8'hc3);
        $display("test time-out done");
        finish_test();
    end
endmodule
`default_nettype wire
